// File: rtl/xfer_decode.sv
// Purpose: Decode data-transfer instructions and report clock counts
// Assumes: Bytes are prefetched; one instruction presented per strobe
// Notes: Base counts per mode and operand kind, plus adjustments
`timescale 1ns/1ps
module xfer_decode #(
  parameter int WAIT_WIDTH = 4
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic instr_valid,
  input wire logic [7:0] byte0,
  input wire logic [7:0] byte1,
  input wire logic [7:0] byte2,
  input wire logic protected_mode,
  input wire logic operand_32,
  input wire logic two_reg_ea,
  input wire logic [1:0] addr_low,
  input wire logic [WAIT_WIDTH-1:0] wait_states,
  output logic result_valid,
  output logic recognised,
  output logic [3:0] op_class,
  output logic full_width,
  output logic memory_operand,
  output logic [2:0] segment_selector_3bit,
  output logic [1:0] segment_selector_2bit,
  output logic [5:0] base_clocks,
  output logic [7:0] total_clocks,
  output logic [2:0] components,
  output logic [31:0] elapsed_ps
);
  xfer_decode_pkg::op_e op;
  logic [1:0] acc;
  logic [1:0] mod_field;
  logic mem;
  logic width_bit;
  logic [5:0] base;
  logic [5:0] align_adj;
  logic [5:0] ea_adj;
  logic [7:0] wait_adj;
  logic [7:0] total;
  logic [2:0] comp;
  logic [2:0] sel3;
  logic [1:0] sel2;
  logic has_modrm;

  // Opcode classification
  always_comb begin
    op = xfer_decode_pkg::OP_NONE;
    mod_field = byte1[7:6];
    has_modrm = 1'b1;
    width_bit = byte0[0];
    sel3 = byte1[5:3];
    sel2 = byte0[4:3];
    if (byte0 == xfer_decode_pkg::OPC_ESCAPE) begin
      mod_field = byte2[7:6];
      width_bit = byte1[0];
      if (byte1[7:1] == xfer_decode_pkg::OPC2_SIGN_EXT) begin
        op = xfer_decode_pkg::OP_SIGN_EXT;
      end else if (byte1[7:1] == xfer_decode_pkg::OPC2_ZERO_EXT) begin
        op = xfer_decode_pkg::OP_ZERO_EXT;
      end else if (byte1[7:6] == xfer_decode_pkg::OPC2_PUSH_SEG3_HI &&
                   byte1[2:0] == xfer_decode_pkg::OPC2_PUSH_SEG3_LO) begin
        op = xfer_decode_pkg::OP_PUSH_SEG3;
        has_modrm = 1'b0;
      end
    end else if (byte0[7:1] == xfer_decode_pkg::OPC_COPY_R2RM) begin
      op = xfer_decode_pkg::OP_COPY_R2RM;
    end else if (byte0[7:1] == xfer_decode_pkg::OPC_COPY_RM2R) begin
      op = xfer_decode_pkg::OP_COPY_RM2R;
    end else if (byte0[7:1] == xfer_decode_pkg::OPC_COPY_I2RM) begin
      op = xfer_decode_pkg::OP_COPY_I2RM;
    end else if (byte0[7:4] == xfer_decode_pkg::OPC_COPY_I2R) begin
      op = xfer_decode_pkg::OP_COPY_I2R;
      width_bit = byte0[3];
      has_modrm = 1'b0;
    end else if (byte0[7:1] == xfer_decode_pkg::OPC_LOAD_ACC) begin
      op = xfer_decode_pkg::OP_LOAD_ACC;
      has_modrm = 1'b0;
    end else if (byte0[7:1] == xfer_decode_pkg::OPC_STORE_ACC) begin
      op = xfer_decode_pkg::OP_STORE_ACC;
      has_modrm = 1'b0;
    end else if (byte0 == xfer_decode_pkg::OPC_RM2SEG) begin
      op = xfer_decode_pkg::OP_RM2SEG;
      width_bit = 1'b1;
    end else if (byte0 == xfer_decode_pkg::OPC_SEG2RM) begin
      op = xfer_decode_pkg::OP_SEG2RM;
      width_bit = 1'b1;
    end else if (byte0 == xfer_decode_pkg::OPC_PUSH_RM &&
                 byte1[5:3] == xfer_decode_pkg::PUSH_RM_REG) begin
      op = xfer_decode_pkg::OP_PUSH_RM;
      width_bit = 1'b1;
    end else if (byte0[7:3] == xfer_decode_pkg::OPC_PUSH_REG) begin
      op = xfer_decode_pkg::OP_PUSH_REG;
      width_bit = 1'b1;
      has_modrm = 1'b0;
    end else if (byte0[7:5] == xfer_decode_pkg::OPC_PUSH_SEG2_HI &&
                 byte0[2:0] == xfer_decode_pkg::OPC_PUSH_SEG2_LO) begin
      op = xfer_decode_pkg::OP_PUSH_SEG2;
      width_bit = 1'b1;
      has_modrm = 1'b0;
    end
    if (op == xfer_decode_pkg::OP_PUSH_SEG3) begin
      width_bit = 1'b1;
      sel3 = byte1[5:3];
    end
  end

  // Memory operand when addressing byte names memory, or form is memory-only
  always_comb begin
    mem = has_modrm && (mod_field != xfer_decode_pkg::MOD_REGISTER);
    unique case (op)
      xfer_decode_pkg::OP_LOAD_ACC, xfer_decode_pkg::OP_STORE_ACC,
      xfer_decode_pkg::OP_PUSH_REG, xfer_decode_pkg::OP_PUSH_SEG2,
      xfer_decode_pkg::OP_PUSH_SEG3: mem = 1'b1;
      default: ;
    endcase
  end

  // Base counts with ideal bus; smaller for register operand, except stores to r/m (same count)
  always_comb begin
    base = 6'h00;
    acc = 2'(xfer_decode_pkg::ACC_NONE);
    unique case (op)
      xfer_decode_pkg::OP_COPY_R2RM, xfer_decode_pkg::OP_COPY_I2RM: begin
        base = xfer_decode_pkg::CNT_2;
        acc = mem ? 2'(xfer_decode_pkg::ACC_WRITE) : 2'(xfer_decode_pkg::ACC_NONE);
      end
      xfer_decode_pkg::OP_COPY_RM2R: begin
        base = mem ? xfer_decode_pkg::CNT_4 : xfer_decode_pkg::CNT_2;
        acc = mem ? 2'(xfer_decode_pkg::ACC_READ) : 2'(xfer_decode_pkg::ACC_NONE);
      end
      xfer_decode_pkg::OP_COPY_I2R: base = xfer_decode_pkg::CNT_2;
      xfer_decode_pkg::OP_LOAD_ACC: begin
        base = xfer_decode_pkg::CNT_4;
        acc = 2'(xfer_decode_pkg::ACC_READ);
      end
      xfer_decode_pkg::OP_STORE_ACC: begin
        base = xfer_decode_pkg::CNT_2;
        acc = 2'(xfer_decode_pkg::ACC_WRITE);
      end
      xfer_decode_pkg::OP_RM2SEG: begin
        if (protected_mode) base = mem ? xfer_decode_pkg::CNT_23 : xfer_decode_pkg::CNT_22;
        else base = mem ? xfer_decode_pkg::CNT_5 : xfer_decode_pkg::CNT_2;
        acc = mem ? 2'(xfer_decode_pkg::ACC_READ) : 2'(xfer_decode_pkg::ACC_NONE);
      end
      xfer_decode_pkg::OP_SEG2RM: begin
        base = xfer_decode_pkg::CNT_2;
        acc = mem ? 2'(xfer_decode_pkg::ACC_WRITE) : 2'(xfer_decode_pkg::ACC_NONE);
      end
      xfer_decode_pkg::OP_SIGN_EXT, xfer_decode_pkg::OP_ZERO_EXT: begin
        base = mem ? xfer_decode_pkg::CNT_6 : xfer_decode_pkg::CNT_3;
        acc = mem ? 2'(xfer_decode_pkg::ACC_READ) : 2'(xfer_decode_pkg::ACC_NONE);
      end
      xfer_decode_pkg::OP_PUSH_RM: begin
        if (protected_mode) base = mem ? xfer_decode_pkg::CNT_9 : xfer_decode_pkg::CNT_7;
        else base = mem ? xfer_decode_pkg::CNT_7 : xfer_decode_pkg::CNT_5;
        acc = mem ? 2'(xfer_decode_pkg::ACC_RMW) : 2'(xfer_decode_pkg::ACC_WRITE);
      end
      xfer_decode_pkg::OP_PUSH_REG, xfer_decode_pkg::OP_PUSH_SEG2,
      xfer_decode_pkg::OP_PUSH_SEG3: begin
        base = protected_mode ? xfer_decode_pkg::CNT_4 : xfer_decode_pkg::CNT_2;
        acc = 2'(xfer_decode_pkg::ACC_WRITE);
      end
      default: ;
    endcase
  end

  // Stack pushes count as one read and one write only for memory source
  align_penalty u_align (
    .addr_low(addr_low),
    .wide(operand_32),
    .full_width(width_bit),
    .access(acc),
    .penalty(align_adj)
  );

  // Component count of this instruction: opcode bytes, addressing, disp, imm
  always_comb begin
    comp = (byte0 == xfer_decode_pkg::OPC_ESCAPE) ? 3'h2 : 3'h1;
    if (has_modrm) comp = comp + 3'h1;
    if (has_modrm && mod_field != xfer_decode_pkg::MOD_REGISTER && mod_field != 2'h0)
      comp = comp + 3'h1;
    if (op == xfer_decode_pkg::OP_LOAD_ACC || op == xfer_decode_pkg::OP_STORE_ACC ||
        op == xfer_decode_pkg::OP_COPY_I2R || op == xfer_decode_pkg::OP_COPY_I2RM)
      comp = comp + 3'h1;
  end

  always_comb begin
    ea_adj = (has_modrm && mem && two_reg_ea) ? xfer_decode_pkg::ADJ_TWO_REG : 6'h00;
    // Read-and-write access pays the wait states twice
    wait_adj = (acc == 2'(xfer_decode_pkg::ACC_RMW)) ? 8'({wait_states, 1'b0})
             : (acc != 2'(xfer_decode_pkg::ACC_NONE)) ? 8'(wait_states) : 8'h00;
    total = 8'(base) + 8'(ea_adj) + 8'(align_adj) + wait_adj;
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) result_valid <= 1'b0;
    else result_valid <= instr_valid;
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      recognised <= 1'b0;
      op_class <= 4'h0;
      full_width <= 1'b0;
      memory_operand <= 1'b0;
      segment_selector_3bit <= 3'h0;
      segment_selector_2bit <= 2'h0;
      base_clocks <= 6'h00;
      total_clocks <= 8'h00;
      components <= 3'h0;
      elapsed_ps <= 32'h0;
    end else if (instr_valid) begin
      recognised <= (op != xfer_decode_pkg::OP_NONE);
      op_class <= 4'(op);
      full_width <= width_bit;
      memory_operand <= mem;
      segment_selector_3bit <= sel3;
      segment_selector_2bit <= sel2;
      base_clocks <= base;
      total_clocks <= total;
      components <= comp;
      elapsed_ps <= 32'(total) * 32'(xfer_decode_pkg::CLK_PERIOD_PS);
    end
  end
endmodule : xfer_decode

// File: rtl/xfer_decode_pkg.sv
// Purpose: Constants for the data-transfer decode and timing block
// Assumes: Opcode bytes arrive already fetched and aligned
// Notes: Counts are processor clocks
package xfer_decode_pkg;
  localparam int CLK_PERIOD_PS = 10000;
  localparam logic [7:0] OPC_ESCAPE = 8'h0F;
  localparam logic [6:0] OPC_COPY_R2RM = 7'h44;
  localparam logic [6:0] OPC_COPY_RM2R = 7'h45;
  localparam logic [6:0] OPC_COPY_I2RM = 7'h63;
  localparam logic [3:0] OPC_COPY_I2R = 4'hB;
  localparam logic [6:0] OPC_LOAD_ACC = 7'h50;
  localparam logic [6:0] OPC_STORE_ACC = 7'h51;
  localparam logic [7:0] OPC_RM2SEG = 8'h8E;
  localparam logic [7:0] OPC_SEG2RM = 8'h8C;
  localparam logic [6:0] OPC2_SIGN_EXT = 7'h5F;
  localparam logic [6:0] OPC2_ZERO_EXT = 7'h5B;
  localparam logic [7:0] OPC_PUSH_RM = 8'hFF;
  localparam logic [4:0] OPC_PUSH_REG = 5'h0A;
  localparam logic [2:0] OPC_PUSH_SEG2_HI = 3'h0;
  localparam logic [2:0] OPC_PUSH_SEG2_LO = 3'h6;
  localparam logic [1:0] OPC2_PUSH_SEG3_HI = 2'h2;
  localparam logic [2:0] OPC2_PUSH_SEG3_LO = 3'h0;
  localparam logic [2:0] PUSH_RM_REG = 3'h6;
  localparam logic [1:0] MOD_REGISTER = 2'h3;
  localparam logic [5:0] CNT_2 = 6'h02;
  localparam logic [5:0] CNT_3 = 6'h03;
  localparam logic [5:0] CNT_4 = 6'h04;
  localparam logic [5:0] CNT_5 = 6'h05;
  localparam logic [5:0] CNT_6 = 6'h06;
  localparam logic [5:0] CNT_7 = 6'h07;
  localparam logic [5:0] CNT_9 = 6'h09;
  localparam logic [5:0] CNT_22 = 6'h16;
  localparam logic [5:0] CNT_23 = 6'h17;
  localparam logic [5:0] ADJ_TWO_REG = 6'h01;
  localparam logic [5:0] ADJ_HALF_RW = 6'h02;
  localparam logic [5:0] ADJ_HALF_RMW = 6'h04;
  localparam logic [5:0] ADJ_ODD_RW = 6'h04;
  localparam logic [5:0] ADJ_ODD_RMW = 6'h08;
  typedef enum logic [1:0] {ACC_NONE, ACC_READ, ACC_WRITE, ACC_RMW} access_e;
  typedef enum logic [3:0] {
    OP_NONE, OP_COPY_R2RM, OP_COPY_RM2R, OP_COPY_I2RM, OP_COPY_I2R,
    OP_LOAD_ACC, OP_STORE_ACC, OP_RM2SEG, OP_SEG2RM, OP_SIGN_EXT,
    OP_ZERO_EXT, OP_PUSH_RM, OP_PUSH_REG, OP_PUSH_SEG2, OP_PUSH_SEG3
  } op_e;
endpackage : xfer_decode_pkg

// File: rtl/align_penalty.sv
// Purpose: Extra clocks for a misaligned or wide data access
// Assumes: Address low bits and operand width known at decode
// Notes: Purely combinational
`timescale 1ns/1ps
module align_penalty (
  input wire logic [1:0] addr_low,
  input wire logic wide,
  input wire logic full_width,
  input wire logic [1:0] access,
  output logic [5:0] penalty
);
  logic rmw;
  logic any_access;
  assign rmw = (access == 2'(xfer_decode_pkg::ACC_RMW));
  assign any_access = (access != 2'(xfer_decode_pkg::ACC_NONE));
  always_comb begin
    penalty = 6'h00;
    if (any_access && full_width) begin
      if (wide && addr_low[0]) begin
        penalty = rmw ? xfer_decode_pkg::ADJ_ODD_RMW : xfer_decode_pkg::ADJ_ODD_RW;
      end else if (wide || addr_low[0]) begin
        // 16-bit odd, or 32-bit even
        penalty = rmw ? xfer_decode_pkg::ADJ_HALF_RMW : xfer_decode_pkg::ADJ_HALF_RW;
      end
    end
  end
endmodule : align_penalty

// File: testbench/xfer_decode_checker.sv
// Purpose: Port-level timing relations of the transfer decoder
// Assumes: One clock domain, async active-low reset
// Notes: Adjustment sums are left to the bench comparisons
`timescale 1ns/1ps
module xfer_decode_checker (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic instr_valid,
  input wire logic [7:0] byte0,
  input wire logic [7:0] byte1,
  input wire logic [7:0] byte2,
  input wire logic protected_mode,
  input wire logic result_valid,
  input wire logic full_width,
  input wire logic [2:0] segment_selector_3bit,
  input wire logic [5:0] base_clocks,
  input wire logic [7:0] total_clocks,
  input wire logic [31:0] elapsed_ps
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  sequence s_esc;
    instr_valid && byte0 == 8'h0F;
  endsequence
  sequence s_ext;
    s_esc ##0 (byte1[7:1] == 7'h5F || byte1[7:1] == 7'h5B);
  endsequence
  a_answer_next: assert property (instr_valid |=> result_valid)
    else $error("result not reported one cycle after request");
  a_quiet_idle: assert property (!instr_valid |=> !result_valid && $stable(total_clocks))
    else $error("result moved with no request");
  a_elapsed_time: assert property (result_valid |-> elapsed_ps == total_clocks * 32'h0000_2710)
    else $error("elapsed time not count times period");
  a_total_sum: assert property (result_valid |-> total_clocks >= {2'h0, base_clocks})
    else $error("total below base count");
  a_imm_short: assert property (instr_valid && byte0[7:4] == 4'hB |=> base_clocks == 6'h02
    && full_width == $past(byte0[3])) else $error("short immediate copy wrong");
  a_acc_load: assert property (instr_valid && byte0[7:1] == 7'h50 |=> base_clocks == 6'h04)
    else $error("accumulator load count wrong");
  a_acc_store: assert property (instr_valid && byte0[7:1] == 7'h51 |=> base_clocks == 6'h02)
    else $error("accumulator store count wrong");
  a_seg_copy: assert property (instr_valid && byte0 == 8'h8C |=> base_clocks == 6'h02
    && segment_selector_3bit == $past(byte1[5:3])) else $error("segment copy wrong");
  a_ext_reg: assert property (s_ext ##0 byte2[7:6] == 2'h3 |=> base_clocks == 6'h03)
    else $error("extending copy register count wrong");
  a_ext_mem: assert property (s_ext ##0 byte2[7:6] != 2'h3 |=> base_clocks == 6'h06)
    else $error("extending copy memory count wrong");
  a_push_seg: assert property (s_esc ##0 byte1[7:6] == 2'h2 && byte1[2:0] == 3'h0
    |=> base_clocks == ($past(protected_mode) ? 6'h04 : 6'h02)) else $error("segment push wrong");
endmodule : xfer_decode_checker
bind xfer_decode xfer_decode_checker chk (.clock, .reset_n, .instr_valid, .byte0, .byte1,
  .byte2, .protected_mode, .result_valid, .full_width, .segment_selector_3bit, .base_clocks,
  .total_clocks, .elapsed_ps);

// File: testbench/data_transfer_decode_timing_test.sv
// Purpose: Self-checking bench for the transfer decoder
// Assumes: One instruction per cycle, answer one cycle later
// Notes: Rows run back to back; reset and odd cases follow the loop
`timescale 1ns/1ps
module data_transfer_decode_timing_test;
  typedef struct packed {
    logic [7:0] b0; logic [7:0] b1; logic [7:0] b2;
    logic [3:0] pm; logic [3:0] o32; logic [3:0] two; logic [3:0] al;
    logic [3:0] ws; logic [3:0] op; logic [7:0] base; logic [7:0] tot;
    logic [3:0] mem; logic [3:0] fw; logic [3:0] s2;
  } row_s;
  localparam int N = 26;
  // Bytes, mode/32-bit/two-reg/addr, waits/class, base, total, memory/width/sel2
  row_s rows [N] = '{
    76'h8B_C3_00_0000_02_02_02_011, 76'h88_00_00_0000_01_02_02_101,
    76'hC7_C0_00_0000_03_02_02_010, 76'hB0_12_00_0000_04_02_02_002,
    76'hB8_34_00_1000_04_02_02_013, 76'hA1_00_00_0101_05_04_08_110,
    76'hA1_00_00_0100_35_04_09_110, 76'hA3_00_00_0001_06_02_04_110,
    76'hA0_00_00_0001_05_04_04_100, 76'h8C_D8_00_0000_08_02_02_011,
    76'h8C_18_00_1000_08_02_02_111, 76'h0F_BF_C0_0000_09_03_03_011,
    76'h0F_BF_00_0010_09_06_07_111, 76'h0F_B6_C0_0000_0A_03_03_001,
    76'h0F_B7_00_0000_2A_06_08_111, 76'h0F_A0_00_0000_0E_02_02_111,
    76'h0F_A8_00_1000_0E_04_04_111, 76'hFF_30_00_0100_1B_07_0D_113,
    76'hFF_30_00_1100_1B_09_0F_113, 76'h90_00_00_0000_00_00_00_102,
    76'h1E_00_00_0000_0D_02_02_113, 76'h16_00_00_1000_0D_04_04_112,
    76'h53_00_00_1102_0C_04_06_112, 76'h8E_D8_00_1000_07_16_16_011,
    76'h8E_18_00_0010_17_05_07_111, 76'hFF_F0_00_0000_2B_05_07_013};
  logic clock, reset_n, instr_valid, protected_mode, operand_32, two_reg_ea;
  logic [7:0] byte0, byte1, byte2, total_clocks;
  logic [1:0] addr_low, segment_selector_2bit;
  logic [3:0] wait_states, op_class;
  logic result_valid, recognised, full_width, memory_operand;
  logic [5:0] base_clocks;
  logic [2:0] components;
  logic [31:0] elapsed_ps;
  int fail_count = 0;
  int n_checks = 0;
  xfer_decode #(.WAIT_WIDTH(4)) uut (.clock, .reset_n, .instr_valid, .byte0, .byte1, .byte2,
    .protected_mode, .operand_32, .two_reg_ea, .addr_low, .wait_states, .result_valid,
    .recognised, .op_class, .full_width, .memory_operand, .segment_selector_3bit(),
    .segment_selector_2bit, .base_clocks, .total_clocks, .components, .elapsed_ps);
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    n_checks++;
    if (seen !== want) begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask : check
  task automatic drive(input row_s r);
    instr_valid <= 1'b1;
    {byte0, byte1, byte2} <= {r.b0, r.b1, r.b2};
    {protected_mode, operand_32, two_reg_ea} <= {r.pm[0], r.o32[0], r.two[0]};
    {addr_low, wait_states} <= {r.al[1:0], r.ws};
  endtask : drive
  task automatic complete_run();
    if (fail_count == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : complete_run
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // Whole run is under a hundred cycles
  initial begin
    #10000;
    fail_count++;
    complete_run();
  end
  initial begin
    reset_n = 1'b0;
    {instr_valid, byte0, byte1, byte2, protected_mode, operand_32} = '0;
    {two_reg_ea, addr_low, wait_states} = '0;
    repeat (16) @(posedge clock);
    #1;
    check({result_valid, total_clocks}, 9'h000);
    @(posedge clock);
    reset_n <= 1'b1;
    drive(rows[0]);
    for (int i = 0; i < N; i++) begin
      @(posedge clock);
      if (i + 1 < N) drive(rows[i + 1]);
      else instr_valid <= 1'b0;
      #1;
      check(result_valid, 1'b1);
      check(op_class, rows[i].op);
      check(recognised, rows[i].op != 4'h0);
      check(base_clocks, rows[i].base[5:0]);
      check(total_clocks, rows[i].tot);
      check(elapsed_ps, rows[i].tot * 32'h0000_2710);
      check(memory_operand, rows[i].mem[0]);
      check(full_width, rows[i].fw[0]);
      check(segment_selector_2bit, rows[i].s2[1:0]);
    end
    // Displacement form: opcode, addressing byte and displacement
    @(posedge clock);
    drive(76'h8B_40_05_0000_02_04_04_111);
    @(posedge clock);
    instr_valid <= 1'b0;
    #1;
    check(components, 3'h3);
    check(total_clocks, 8'h04);
    repeat (3) @(posedge clock);
    #1;
    check({result_valid, total_clocks}, 9'h004);
    @(posedge clock);
    reset_n <= 1'b0;
    #1;
    check({result_valid, total_clocks}, 9'h000);
    @(posedge clock);
    reset_n <= 1'b1;
    drive(rows[5]);
    @(posedge clock);
    instr_valid <= 1'b0;
    #1;
    check(total_clocks, rows[5].tot);
    complete_run();
  end
endmodule : data_transfer_decode_timing_test
